// ### hdl/lsil_pkg.sv
// Package for the LCD segment loader: bus constants, control layout,
// state encoding and the word that crosses into the display domain.
// Assumes every user writes lsil_pkg::name; nothing is imported.
package lsil_pkg;

  // Fixed write address byte, read/write bit included
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'h74;
  // Bits per serial byte before the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Number of pattern bytes held
  localparam int PATTERN_COUNT = 8;

  // Control byte field positions
  localparam int CTRL_MODE_BIT = 7;
  localparam int CTRL_BANK_BIT = 6;
  localparam int CTRL_PTR_LSB = 0;
  localparam int CTRL_PTR_MSB = 5;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;

  // Pointer steps in each drive mode
  localparam logic [5:0] PTR_STEP_DIRECT = 6'h02;
  localparam logic [5:0] PTR_STEP_DUPLEX = 6'h01;

  // Drive mode encodings of the mode bit
  localparam logic MODE_DIRECT = 1'b0;
  localparam logic MODE_DUPLEX = 1'b1;

  // Display phase value loaded at reset
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // Control register as software sees it
  typedef struct packed {
    logic mode;
    logic bank;
    logic [5:0] load_pointer;
  } lsil_ctrl_type;

  // Everything the display domain needs, moved as one word
  typedef struct packed {
    logic mode;
    logic bank;
    logic [7:0][7:0] pattern;
  } lsil_disp_type;

  // Serial receiver states
  typedef enum logic [2:0] {
    LSIL_IDLE,
    LSIL_ADDR,
    LSIL_ADDR_ACK,
    LSIL_CTRL,
    LSIL_CTRL_ACK,
    LSIL_DATA,
    LSIL_DATA_ACK,
    LSIL_SKIP
  } lsil_state_type;

endpackage

// ### hdl/lsil_loader.sv
// Write-only two-wire slave that loads a control byte and eight segment
// pattern bytes, and drives a direct or duplex segment display from them.
// Assumes serial pins and straps are asynchronous to i_mclk, and that
// i_lcd_clk is the display step clock from the local oscillator.
`timescale 1ns/1ps

// Contract
// [R01] One control byte, eight pattern bytes, two pages
// [R02] All devices acknowledge address and load control
// [R03] Upper pointer bits match straps to enable loading
// [R04] Lower pointer bits choose the pattern byte
// [R05] Mode bit zero gives direct drive, four bytes
// [R06] Direct mode shows page chosen by page bit
// [R07] Direct mode pointer advances by two
// [R08] Either page loads any time, whatever shown
// [R09] Duplex uses shared pin as second backplane
// [R10] Duplex selects device on two lower straps
// [R11] Duplex advances pointer by one, ignores page
// [R12] Every device advances the pointer the same
// [R13] Unlimited bytes, six-bit pointer wraps around
// [R14] Stop after control leaves patterns unchanged
// [R15] Only the selected device acknowledges pattern bytes
// [R16] Master sends address, control, patterns, then stop
// [R17] Reset clears registers, segments held low
// [R18] Reset backplanes low, or released when cascaded; first backplane is still driven low in reset when cascaded
// [R19] Low strap reads one only when tied high
// [R20] Unconnected top strap reads zero in direct
// [R21] Cascade mode takes timing from backplane input
// [R22] Responds to address byte 0111 0100
// [R23] Duplex pairs even/odd bytes with two backplanes
// [R24] Never acknowledges reads, never drives data
module lsil_loader (
  // Core clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Display step clock
  input wire logic i_lcd_clk,
  // Serial bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Subaddress straps and oscillator sense
  input wire logic i_low_strap_oscillator_pin,
  input wire logic i_cascade_mode,
  input wire logic i_middle_strap_input,
  // Shared top strap / second backplane pin
  input wire logic i_top_strap_second_backplane_pin,
  output logic o_top_strap_second_backplane_pin,
  output logic o_top_strap_second_backplane_pin_oe,
  // First backplane pin, also cascade sync input
  input wire logic i_first_backplane_out,
  output logic o_first_backplane_out,
  output logic o_first_backplane_out_oe,
  // Segment drive
  output logic [31:0] o_segment_outputs
);

  // Reset release synchronisers, one per domain
  logic rst_m1_r;
  logic rst_m2_r;
  logic rst_l1_r;
  logic rst_l2_r;
  logic rst_n;
  logic lrst_n;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_m1_r <= 1'b0;
      rst_m2_r <= 1'b0;
    end else begin
      rst_m1_r <= 1'b1;
      rst_m2_r <= rst_m1_r;
    end
  end

  always_ff @(posedge i_lcd_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_l1_r <= 1'b0;
      rst_l2_r <= 1'b0;
    end else begin
      rst_l1_r <= 1'b1;
      rst_l2_r <= rst_l1_r;
    end
  end

  assign rst_n = rst_m2_r;
  assign lrst_n = rst_l2_r;

  // Pin synchronisers in the core domain
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic scl_q_r;
  logic sda_q_r;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 6'h1f;
      pin_s2_r <= 6'h1f;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      pin_s1_r <= {i_cascade_mode, i_scl, i_sda, i_low_strap_oscillator_pin,
                   i_middle_strap_input, i_top_strap_second_backplane_pin};
      pin_s2_r <= pin_s1_r;
      scl_q_r <= pin_s2_r[4];
      sda_q_r <= pin_s2_r[3];
    end
  end

  // Bus events seen on the synchronised lines
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_s = pin_s2_r[4];
  assign sda_s = pin_s2_r[3];
  assign scl_rise = scl_s && !scl_q_r;
  assign scl_fall = !scl_s && scl_q_r;
  assign start_seen = scl_s && scl_q_r && !sda_s && sda_q_r;
  assign stop_seen = scl_s && scl_q_r && sda_s && !sda_q_r;

  // Control register and pattern store
  lsil_pkg::lsil_ctrl_type ctrl_r;
  logic [7:0] pat_r [lsil_pkg::PATTERN_COUNT];

  // Strap decode: own oscillator forces low strap to zero
  logic strap_low;
  logic strap_mid;
  logic strap_top;
  logic dev_selected;

  assign strap_low = pin_s2_r[5] && pin_s2_r[2]; // [R19]
  assign strap_mid = pin_s2_r[1];
  assign strap_top = pin_s2_r[0]; // [R20]

  // Device match on pointer upper bits
  function automatic logic ptr_match(input lsil_pkg::lsil_ctrl_type c, input logic a2,
                                     input logic a1, input logic a0);
    if (c.mode == lsil_pkg::MODE_DUPLEX) begin
      ptr_match = (c.load_pointer[4:3] == {a1, a0}); // [R10]
    end else begin
      ptr_match = (c.load_pointer[5:3] == {a2, a1, a0}); // [R03]
    end
  endfunction

  assign dev_selected = ptr_match(ctrl_r, strap_top, strap_mid, strap_low);

  // Pointer step chosen by drive mode, six-bit wrap
  function automatic logic [5:0] ptr_next(input lsil_pkg::lsil_ctrl_type c);
    if (c.mode == lsil_pkg::MODE_DUPLEX) begin
      ptr_next = c.load_pointer + lsil_pkg::PTR_STEP_DUPLEX; // [R11] [R13]
    end else begin
      ptr_next = c.load_pointer + lsil_pkg::PTR_STEP_DIRECT; // [R07] [R13]
    end
  endfunction

  // Receiver state, bit count and shift register
  lsil_pkg::lsil_state_type state_r;
  lsil_pkg::lsil_state_type state_nxt;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic ack_r;
  logic byte_done;

  assign byte_done = scl_fall && (bit_cnt_r == lsil_pkg::BITS_PER_BYTE);

  // Next state of the receiver; stop and start win over bits
  always_comb begin
    state_nxt = state_r;
    if (stop_seen) begin
      state_nxt = lsil_pkg::LSIL_IDLE; // [R14]
    end else if (start_seen) begin
      state_nxt = lsil_pkg::LSIL_ADDR;
    end else begin
      case (state_r)
        lsil_pkg::LSIL_ADDR: begin
          if (byte_done) begin
            if (shift_r == lsil_pkg::SLAVE_ADDR_BYTE) begin // [R22] [R24]
              state_nxt = lsil_pkg::LSIL_ADDR_ACK;
            end else begin
              state_nxt = lsil_pkg::LSIL_SKIP;
            end
          end
        end
        lsil_pkg::LSIL_ADDR_ACK: begin
          if (scl_fall) begin
            state_nxt = lsil_pkg::LSIL_CTRL;
          end
        end
        lsil_pkg::LSIL_CTRL: begin
          if (byte_done) begin
            state_nxt = lsil_pkg::LSIL_CTRL_ACK;
          end
        end
        lsil_pkg::LSIL_CTRL_ACK: begin
          if (scl_fall) begin
            state_nxt = lsil_pkg::LSIL_DATA;
          end
        end
        lsil_pkg::LSIL_DATA: begin
          if (byte_done) begin
            state_nxt = lsil_pkg::LSIL_DATA_ACK;
          end
        end
        lsil_pkg::LSIL_DATA_ACK: begin
          if (scl_fall) begin
            state_nxt = lsil_pkg::LSIL_DATA; // [R13]
          end
        end
        lsil_pkg::LSIL_IDLE: state_nxt = lsil_pkg::LSIL_IDLE;
        lsil_pkg::LSIL_SKIP: state_nxt = lsil_pkg::LSIL_SKIP;
        default: state_nxt = lsil_pkg::LSIL_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= lsil_pkg::LSIL_IDLE; // [R17]
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit counter and shifter; the counter is cleared at start and at each ack slot
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end else if (start_seen || (scl_fall && (state_r == lsil_pkg::LSIL_ADDR_ACK ||
                 state_r == lsil_pkg::LSIL_CTRL_ACK || state_r == lsil_pkg::LSIL_DATA_ACK))) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && bit_cnt_r != lsil_pkg::BITS_PER_BYTE) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r <= {shift_r[6:0], sda_s};
    end
  end

  // Acknowledge drive: pulled low from the eighth fall to the ninth
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else if (stop_seen || start_seen) begin
      ack_r <= 1'b0;
    end else if (byte_done) begin
      case (state_r)
        lsil_pkg::LSIL_ADDR: ack_r <= (shift_r == lsil_pkg::SLAVE_ADDR_BYTE); // [R02]
        lsil_pkg::LSIL_CTRL: ack_r <= 1'b1; // [R02]
        lsil_pkg::LSIL_DATA: ack_r <= dev_selected; // [R15]
        default: ack_r <= 1'b0;
      endcase
    end else if (scl_fall) begin
      ack_r <= 1'b0;
    end
  end

  // Open-drain data line: only ever pulls low for acknowledge
  assign o_sda = 1'b0; // [R24]
  assign o_sda_oe = ack_r;

  // Control byte load and pointer advance on every data byte
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= lsil_pkg::lsil_ctrl_type'(lsil_pkg::CTRL_RESET); // [R17]
    end else if (byte_done && state_r == lsil_pkg::LSIL_CTRL) begin
      ctrl_r <= lsil_pkg::lsil_ctrl_type'(shift_r); // [R02]
    end else if (byte_done && state_r == lsil_pkg::LSIL_DATA) begin
      ctrl_r.load_pointer <= ptr_next(ctrl_r); // [R12]
    end
  end

  // Pattern store written only when this device is selected
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < lsil_pkg::PATTERN_COUNT; i++) begin
        pat_r[i] <= lsil_pkg::PATTERN_RESET; // [R17]
      end
    end else if (byte_done && state_r == lsil_pkg::LSIL_DATA && dev_selected) begin
      pat_r[ctrl_r.load_pointer[2:0]] <= shift_r; // [R04] [R08]
    end
  end

  // Live display word assembled from the store
  lsil_pkg::lsil_disp_type live;

  always_comb begin
    live.mode = ctrl_r.mode;
    live.bank = ctrl_r.bank;
    for (int i = 0; i < lsil_pkg::PATTERN_COUNT; i++) begin
      live.pattern[i] = pat_r[i]; // [R01]
    end
  end

  // Handshake toward the display domain: snapshot stays still while pending
  lsil_pkg::lsil_disp_type snap_r;
  logic req_r;
  logic ack_s1_r;
  logic ack_s2_r;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      snap_r <= '0;
      req_r <= 1'b0;
    end else if (req_r == ack_s2_r && snap_r != live) begin
      snap_r <= live;
      req_r <= ~req_r;
    end
  end

  // Flag: duplex mode of the captured word, seen in the display domain, drives pin direction
  logic mode_s1_r;
  logic mode_s2_r;

  // Display domain: request synchroniser and captured word
  logic req_s1_r;
  logic req_s2_r;
  logic req_s3_r;
  logic lack_r;
  lsil_pkg::lsil_disp_type disp_r;

  always_ff @(posedge i_lcd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      lack_r <= 1'b0;
      disp_r <= '0;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      if (req_s2_r != req_s3_r) begin
        disp_r <= snap_r;
        lack_r <= req_s2_r;
      end
    end
  end

  // Acknowledge back into the core domain
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= lack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  // Cascade strap and backplane sync input into the display domain
  logic casc_s1_r;
  logic casc_s2_r;
  logic bp_s1_r;
  logic bp_s2_r;
  logic bp_q_r;

  always_ff @(posedge i_lcd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      casc_s1_r <= 1'b0;
      casc_s2_r <= 1'b0;
      bp_s1_r <= 1'b0;
      bp_s2_r <= 1'b0;
      bp_q_r <= 1'b0;
      mode_s1_r <= 1'b0;
      mode_s2_r <= 1'b0;
    end else begin
      casc_s1_r <= i_cascade_mode;
      casc_s2_r <= casc_s1_r;
      bp_s1_r <= i_first_backplane_out;
      bp_s2_r <= bp_s1_r;
      bp_q_r <= bp_s2_r;
      mode_s1_r <= disp_r.mode;
      mode_s2_r <= mode_s1_r;
    end
  end

  // Frame phase: free running, or restarted by the owner's backplane edge
  logic [1:0] phase_r;

  always_ff @(posedge i_lcd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      phase_r <= lsil_pkg::PHASE_RESET;
    end else if (casc_s2_r && bp_s2_r && !bp_q_r) begin
      phase_r <= lsil_pkg::PHASE_RESET + 2'h1; // [R21]
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Backplane and segment levels from phase and captured word
  logic bp1_nxt;
  logic bp2_nxt;
  logic [31:0] seg_nxt;

  always_comb begin
    bp1_nxt = 1'b0;
    bp2_nxt = 1'b0;
    seg_nxt = '0;
    for (int k = 0; k < 4; k++) begin
      if (disp_r.mode == lsil_pkg::MODE_DUPLEX) begin
        // Phases 0/1 serve the first plane, 2/3 the second
        if (!phase_r[1]) begin
          seg_nxt[8*k +: 8] = disp_r.pattern[2*k] ^ {8{phase_r[0]}}; // [R23]
        end else begin
          seg_nxt[8*k +: 8] = disp_r.pattern[2*k+1] ^ {8{phase_r[0]}}; // [R11] [R23]
        end
      end else begin
        seg_nxt[8*k +: 8] = disp_r.pattern[2*k + int'(disp_r.bank)] ^ {8{phase_r[0]}}; // [R05] [R06]
      end
    end
    if (disp_r.mode == lsil_pkg::MODE_DUPLEX) begin
      bp1_nxt = !phase_r[1] && !phase_r[0];
      bp2_nxt = phase_r[1] && !phase_r[0]; // [R09]
    end else begin
      bp1_nxt = phase_r[0]; // [R23]
    end
  end

  // Output flops: segments and backplanes low from reset
  logic [31:0] seg_r;
  logic bp1_r;
  logic bp2_r;

  always_ff @(posedge i_lcd_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      seg_r <= '0; // [R17]
      bp1_r <= 1'b0; // [R18]
      bp2_r <= 1'b0; // [R18]
    end else begin
      seg_r <= seg_nxt;
      bp1_r <= bp1_nxt;
      bp2_r <= bp2_nxt;
    end
  end

  // Pin drive: cascaded devices release both backplanes after reset; during reset the first is driven low
  assign o_segment_outputs = seg_r;
  assign o_first_backplane_out = bp1_r;
  assign o_first_backplane_out_oe = !casc_s2_r; // [R18] [R21]
  assign o_top_strap_second_backplane_pin = bp2_r;
  assign o_top_strap_second_backplane_pin_oe = mode_s2_r && !casc_s2_r; // [R09]

endmodule

// ### verification/lsil_loader_assertions.sv
// Checker for the segment loader: serial acknowledge timing and backplane outputs.
// Assumes it is bound to lsil_loader and sees only that module's ports.
`timescale 1ns/1ps

module lsil_loader_chk (
  // Clocks and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_lcd_clk,
  // Serial pins and straps
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_cascade_mode,
  // Watched outputs
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_first_backplane_out,
  input wire logic o_first_backplane_out_oe,
  input wire logic o_top_strap_second_backplane_pin,
  input wire logic [31:0] o_segment_outputs
);

  // Outputs still blank at the first edge after release
  property p_reset_quiet;
    @(posedge i_mclk) disable iff (!i_arst_n)
    $rose(i_arst_n) |-> o_segment_outputs == 32'h0000_0000 && !o_sda_oe && !o_first_backplane_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active at reset release");

  // Data line is only ever pulled low
  property p_sda_low;
    @(posedge i_mclk) disable iff (!i_arst_n) o_sda_oe |-> !o_sda;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("slave drives a high level");

  // Acknowledge starts only in a low clock phase
  property p_ack_rise;
    @(posedge i_mclk) disable iff (!i_arst_n) $rose(o_sda_oe) |-> !i_scl && !$past(i_scl, 2);
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("acknowledge began off the low phase");

  // Acknowledge ends only after the next clock fall
  property p_ack_fall;
    @(posedge i_mclk) disable iff (!i_arst_n) $fell(o_sda_oe) |-> !i_scl && !$past(i_scl, 2);
  endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("acknowledge released while clock high");

  // Acknowledge is held for eight core clocks after it starts
  property p_ack_hold;
    @(posedge i_mclk) disable iff (!i_arst_n) $rose(o_sda_oe) |=> o_sda_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge too short");

  // Stop leaves the line released
  property p_stop_quiet;
    @(posedge i_mclk) disable iff (!i_arst_n) i_scl && $rose(i_sda) |=> (!o_sda_oe) [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("line pulled after stop");

  // Own oscillator: first backplane is driven
  property p_bp1_driven;
    @(posedge i_lcd_clk) disable iff (!i_arst_n) (!i_cascade_mode) [*4] |-> o_first_backplane_out_oe;
  endproperty
  a_bp1_driven: assert property (p_bp1_driven) else $error("first backplane not driven");

  // The two backplanes are never active together
  property p_bp_excl;
    @(posedge i_lcd_clk) disable iff (!i_arst_n)
    !(o_first_backplane_out && o_top_strap_second_backplane_pin);
  endproperty
  a_bp_excl: assert property (p_bp_excl) else $error("both backplanes active");

endmodule

bind lsil_loader lsil_loader_chk u_chk (
  .i_mclk, .i_arst_n, .i_lcd_clk, .i_scl, .i_sda, .i_cascade_mode, .o_sda, .o_sda_oe,
  .o_first_backplane_out, .o_first_backplane_out_oe, .o_top_strap_second_backplane_pin,
  .o_segment_outputs
);

// ### verification/lsil_bus_master.sv
// Behavioural two-wire bus master: start, byte with acknowledge, stop.
// Assumes a pull-up on the data line; driving 1 means releasing it.
`timescale 1ns/1ps

module lsil_bus_master (
  // Bench clock
  input wire logic i_clk,
  // Bus lines
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);

  // Idle bus, both lines released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Wait a number of falling edges
  task automatic gap(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Data falls while clock high
  task automatic start();
    o_sda = 1'b1;
    gap(5);
    o_scl = 1'b1;
    gap(10);
    o_sda = 1'b0;
    gap(10);
    o_scl = 1'b0;
  endtask

  // Eight bits first to last, then a released acknowledge slot
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      gap(5);
      o_sda = b[i];
      gap(5);
      o_scl = 1'b1;
      gap(10);
      o_scl = 1'b0;
    end
    gap(5);
    o_sda = 1'b1;
    gap(5);
    o_scl = 1'b1;
    gap(5);
    ack = !i_sda;
    gap(5);
    o_scl = 1'b0;
  endtask

  // Data rises while clock high
  task automatic stop();
    gap(5);
    o_sda = 1'b0;
    gap(5);
    o_scl = 1'b1;
    gap(10);
    o_sda = 1'b1;
    gap(10);
  endtask

endmodule

// ### verification/tb_lsil_loader.sv
// Bench for the segment loader: loads through the bus master, checks the display.
// Assumes middle and top straps tied low, low strap pin tied high; cascade set late.
`timescale 1ns/1ps

module tb_lsil_loader;
  logic mclk = 1'b0;
  logic lcd_clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl, m_sda, sda_line, sda_o, sda_oe, bp1_o, bp1_oe, bp2_o, bp2_oe, a;
  logic [31:0] seg;
  logic [7:0] pat [8];
  logic [7:0] bad [3] = '{8'h75, 8'h76, 8'h34};
  logic [5:0] ptr;
  logic casc = 1'b0;
  logic own_bp = 1'b0;
  logic bp1_pin;
  int n_fail = 0;
  int n_tests = 0;

  // Core clock and unrelated display clock
  always #10 mclk = ~mclk;
  initial begin
    #3.7;
    forever #6 lcd_clk = ~lcd_clk;
  end

  // Open-drain data line with pull-up
  assign sda_line = m_sda & ~(sda_oe & ~sda_o);

  // Oscillator owner's backplane, five display steps per period
  always #30 own_bp = ~own_bp;
  // Backplane pin: own drive, else the owner's level once released
  assign bp1_pin = bp1_oe ? bp1_o : own_bp;

  lsil_bus_master M (.i_clk(mclk), .o_scl(scl), .o_sda(m_sda), .i_sda(sda_line));

  // Top strap tied to 0 on the port
  lsil_loader DUT (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_lcd_clk(lcd_clk), .i_scl(scl), .i_sda(sda_line),
    .o_sda(sda_o), .o_sda_oe(sda_oe), .i_low_strap_oscillator_pin(1'b1),
    .i_cascade_mode(casc), .i_middle_strap_input(1'b0),
    .i_top_strap_second_backplane_pin(1'b0), .o_top_strap_second_backplane_pin(bp2_o),
    .o_top_strap_second_backplane_pin_oe(bp2_oe), .i_first_backplane_out(bp1_pin),
    .o_first_backplane_out(bp1_o), .o_first_backplane_out_oe(bp1_oe),
    .o_segment_outputs(seg)
  );

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s ended, mismatches %0d", s, n_fail);
  endtask

  // Full transfer; selection and pointer step worked out here
  task automatic load(input logic [7:0] ctrl, input int n, input logic [7:0] base);
    logic sel;
    M.start();
    M.put(8'h74, a);
    chk(32'(a), 32'h1);
    M.put(ctrl, a);
    chk(32'(a), 32'h1);
    ptr = ctrl[5:0];
    for (int i = 0; i < n; i++) begin
      // Low strap pin is high, so it counts only in cascade
      sel = ctrl[7] ? (ptr[4:3] == {1'b0, casc}) : (ptr[5:3] == {2'b00, casc});
      M.put(base + 8'(i), a);
      chk(32'(a), 32'(sel));
      if (sel)
        pat[ptr[2:0]] = base + 8'(i);
      ptr = ptr + (ctrl[7] ? 6'h01 : 6'h02);
    end
    M.stop();
    repeat (60) @(negedge mclk);
  endtask

  // Direct drive: page bytes, inverted with the backplane
  task automatic show(input int b);
    repeat (4) @(negedge lcd_clk);
    chk(seg, {pat[6+b], pat[4+b], pat[2+b], pat[b]} ^ {32{bp1_o}});
  endtask

  // Duplex: even bytes on first plane, odd on second
  task automatic show_dup();
    int k;
    k = 0;
    while (bp1_o !== 1'b1 && k < 40) begin
      @(negedge lcd_clk);
      k++;
    end
    chk(32'(k < 40), 32'h1);
    chk(seg, {pat[6], pat[4], pat[2], pat[0]});
    k = 0;
    while (bp2_o !== 1'b1 && k < 40) begin
      @(negedge lcd_clk);
      k++;
    end
    chk(32'(k < 40), 32'h1);
    chk(seg, {pat[7], pat[5], pat[3], pat[1]});
  endtask

  // Watchdog
  initial begin
    #1_000_000;
    n_fail++;
    end_sim();
  end

  // Main sequence
  initial begin
    foreach (pat[i]) pat[i] = 8'h00;
    repeat (10) @(negedge mclk);
    chk(seg, 32'h0000_0000);
    chk(32'({sda_oe, bp1_o, bp2_o, bp1_oe}), 32'h0000_0001);
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (5) @(negedge mclk);
    load(8'h00, 4, 8'h11);
    show(0);
    done("direct page A");
    load(8'h01, 4, 8'h51);
    show(0);
    M.start();
    M.put(8'h74, a);
    M.put(8'h41, a);
    chk(32'(a), 32'h1);
    M.stop();
    repeat (60) @(negedge mclk);
    show(1);
    done("page B and bank toggle");
    load(8'h48, 2, 8'hA0);
    load(8'h60, 2, 8'hA8);
    show(1);
    foreach (bad[j]) begin
      M.start();
      M.put(bad[j], a);
      chk(32'(a), 32'h0);
      M.put(8'h02, a);
      chk(32'(a), 32'h0);
      M.stop();
    end
    repeat (60) @(negedge mclk);
    show(1);
    done("refused transfers");
    load(8'hE0, 8, 8'hC0);
    chk(32'(bp2_oe), 32'h1);
    show_dup();
    load(8'hBF, 2, 8'h33);
    show_dup();
    done("duplex and wrap");
    // Cascade: both backplanes released, low strap now reads high
    casc = 1'b1;
    repeat (20) @(negedge mclk);
    chk(32'({bp1_oe, bp2_oe}), 32'h0);
    load(8'h08, 1, 8'h5A);
    show(0);
    // Phase restarts at each owner rise: first plane high four steps later
    repeat (2) begin
      @(posedge own_bp);
      repeat (4) @(posedge lcd_clk);
      @(negedge lcd_clk);
      chk(32'(bp1_o), 32'h1);
    end
    done("cascade");
    end_sim();
  end

endmodule
